// file: vc_arb_pkg.sv
// constants for the vc arbitration status and capability register block
// assumes config accesses arrive as dword-aligned extended offsets
package vc_arb_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h15C;
  localparam logic [11:0] STATE_OFFSET = 12'h15E;
  localparam logic [11:0] CAP_OFFSET = 12'h160;
  localparam logic [11:0] CTRL_DWORD = 12'h15C;
  localparam int unsigned APPLY_BIT = 0;
  localparam int unsigned CHANGED_BIT = 0;
  localparam int unsigned STATE_LANE = 16;
  localparam logic [15:0] STATE_RESET = 16'h0000;
  localparam logic [31:0] CAP_VALUE = 32'h0000_0001;
  localparam logic [7:0] PORT_TABLE_LOCATION = 8'h00;
  localparam logic [6:0] TIME_SLOT_LIMIT = 7'h00;
  localparam logic [7:0] PORT_SCHEME_SUPPORT = 8'h01;
  localparam logic [3:0] REFRESH_CYCLES = 4'h4;
  typedef enum logic [1:0] {IDLE, COPYING} refresh_state_t;
endpackage : vc_arb_pkg

// file: cfg_if.sv
// carrier between the register block and its refresh sequencer
// assumes both ends share i_core_clk
`timescale 1ns/1ps
interface cfg_if;
  logic apply_pulse;
  logic refresh_done;
  logic refresh_busy;
  modport regs (output apply_pulse, input refresh_done, input refresh_busy);
  modport seq (input apply_pulse, output refresh_done, output refresh_busy);
endinterface : cfg_if

// file: vc_table_refresh.sv
// copies the config arbitration table into the working tables
// assumes apply requests come as one-cycle pulses
`timescale 1ns/1ps
module vc_table_refresh
  import vc_arb_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_arst_n, // async reset, active low
  cfg_if.seq cfg, // request and completion
  output logic o_copy_en // working-table copy strobe
);
  typedef struct packed {
    refresh_state_t st;
    logic [3:0] cnt;
    logic done;
  } seq_t;
  seq_t s, next_s;
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.st)
      IDLE: if (cfg.apply_pulse) begin
        next_s.st = COPYING;
        next_s.cnt = REFRESH_CYCLES;
      end
      COPYING: if (s.cnt == 4'h1) begin
        next_s.st = IDLE;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 4'h1;
      end
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '{st: IDLE, cnt: 4'h0, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign cfg.refresh_done = s.done;
  assign cfg.refresh_busy = (s.st == COPYING);
  assign o_copy_en = (s.st == COPYING);
  // done is registered, so it shows one edge after the last copy cycle
  a_refresh_length: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (s.st == IDLE && cfg.apply_pulse) |-> ##5 s.done)
    else $error("refresh length wrong");
endmodule : vc_table_refresh

// file: vc_arbitration_status_capability_regs.sv
// port_vc_state, vc0 resource capability and the control apply strobe
// assumes one config access per cycle, dword address, byte enables
// Summary of operation
// - port vc state is read-only, 16 bits at 15Eh, resets to zero
// - state bits 15:1 always read zero
// - changed flag sets whenever any arbitration table entry is written
// - changed flag clears only after a requested refresh has completed
// - writing one to apply bit at 15Ch starts refresh unless one is already running; bit reads zero
// - vc0 resource capability is read-only at 160h, fixed 0000_0001h
// - port table location bits 31:24 read 00h
// - capability bit 23 reads zero
// - time slot limit bits 22:16 read zero
// - snoop refusal bit 15 reads zero
// - advanced packet only bit 14 reads zero
// - capability bits 13:8 read zero
// - scheme support field: one bit per arbitration scheme
// - scheme support field returns 01h, fixed round-robin only
`timescale 1ns/1ps
module vc_arbitration_status_capability_regs
(
  input wire logic i_core_clk, // core clock, 100 MHz
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_cfg_rd, // config read strobe
  input wire logic i_cfg_wr, // config write strobe
  input wire logic [vc_arb_pkg::ADDR_W-1:0] i_cfg_addr, // dword-aligned offset
  input wire logic [3:0] i_cfg_be, // byte enables
  input wire logic [31:0] i_cfg_wdata, // write data
  input wire logic i_table_write, // an arbitration table entry was written
  output logic [31:0] o_cfg_rdata, // read data, one cycle after read
  output logic o_cfg_rvalid, // read data valid pulse
  output logic o_copy_en // working tables being loaded
);
  import vc_arb_pkg::*;
  typedef struct packed {
    logic changed;
    logic pending;
    logic [31:0] rdata;
    logic rvalid;
    logic copy_en;
  } regs_t;
  regs_t r, next_r;
  cfg_if cfg ();
  logic copy_en_w;
  logic apply;
  logic [31:0] cap_word;
  assign cap_word = {PORT_TABLE_LOCATION, 1'b0, TIME_SLOT_LIMIT,
                     1'b0, 1'b0, 6'h00, PORT_SCHEME_SUPPORT};
  // write to control dword, byte lane 0, bit 0 set requests a refresh
  assign apply = i_cfg_wr && i_cfg_addr == CTRL_DWORD && i_cfg_be[0]
                 && i_cfg_wdata[APPLY_BIT];
  assign cfg.apply_pulse = apply;
  vc_table_refresh u_refresh (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .cfg(cfg.seq),
    .o_copy_en(copy_en_w)
  );
  always_comb begin
    next_r = r;
    next_r.rvalid = i_cfg_rd;
    next_r.copy_en = copy_en_w;
    // a refresh only clears the flag if it was asked for
    if (apply) begin
      next_r.pending = 1'b1;
    end else if (cfg.refresh_done) begin
      next_r.pending = 1'b0;
    end
    if (cfg.refresh_done && r.pending) begin
      next_r.changed = 1'b0;
    end
    // a table write in the same cycle as completion wins
    if (i_table_write) begin
      next_r.changed = 1'b1;
    end
    next_r.rdata = 32'h0000_0000;
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        CTRL_DWORD: next_r.rdata = {15'h0000, r.changed, 16'h0000};
        CAP_OFFSET: next_r.rdata = cap_word;
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '{changed: STATE_RESET[CHANGED_BIT], pending: 1'b0, rdata: 32'h0000_0000,
             rvalid: 1'b0, copy_en: 1'b0};
    end else begin
      r <= next_r;
    end
  end
  assign o_cfg_rdata = r.rdata;
  assign o_cfg_rvalid = r.rvalid;
  assign o_copy_en = r.copy_en;

  // capability word: every field is a fixed constant
  a_cap_fixed: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata == 32'h0000_0001)
    else $error("capability value wrong");
  a_cap_location: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[31:24] == 8'h00)
    else $error("port table location not zero");
  a_cap_bit23: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[23] == 1'b0)
    else $error("capability bit 23 set");
  a_cap_slots: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[22:16] == 7'h00)
    else $error("time slot limit not zero");
  a_cap_snoop: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[15] == 1'b0)
    else $error("snoop refusal bit set");
  a_cap_packet_only: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[14] == 1'b0)
    else $error("advanced packet only bit set");
  a_cap_reserved: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[13:8] == 6'h00)
    else $error("capability reserved bits set");
  a_cap_schemes: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[7:6] == 2'b00)
    else $error("reserved scheme bits set");
  a_cap_round_robin: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata[7:0] == 8'h01)
    else $error("scheme support not round-robin only");
  a_cap_not_written: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_wr && i_cfg_addr == CAP_OFFSET) ##2 (i_cfg_rd && i_cfg_addr == CAP_OFFSET)
    |=> o_cfg_rdata == 32'h0000_0001)
    else $error("capability changed by write");

  // shared control and state dword, read timing
  a_state_reserved: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CTRL_DWORD)
    |=> o_cfg_rdata[31:17] == 15'h0000)
    else $error("state reserved bits set");
  a_apply_reads_zero: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CTRL_DWORD)
    |=> o_cfg_rdata[0] == 1'b0)
    else $error("apply bit read back");
  a_ctrl_half_zero: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CTRL_DWORD)
    |=> o_cfg_rdata[15:0] == 16'h0000)
    else $error("control half not zero");
  a_read_visible: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr == CTRL_DWORD)
    |=> o_cfg_rdata[16] == $past(r.changed))
    else $error("state read mismatch");
  a_rvalid_timing: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_cfg_rd
    |=> o_cfg_rvalid)
    else $error("read answer late");
  a_rvalid_pulse: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_cfg_rd
    |=> !o_cfg_rvalid)
    else $error("read valid without read");
  a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_cfg_rd
    |=> o_cfg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && i_cfg_addr != CTRL_DWORD && i_cfg_addr != CAP_OFFSET)
    |=> o_cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // changed flag: set by table writes, cleared only by a requested refresh
  a_flag_sets: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_table_write
    |=> r.changed)
    else $error("changed flag not set");
  a_flag_holds: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (r.changed && !(cfg.refresh_done && r.pending))
    |=> r.changed)
    else $error("changed flag cleared early");
  a_flag_clears: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (r.changed && apply && !i_table_write) ##1 (!i_table_write)[*6]
    |-> !r.changed)
    else $error("changed flag not cleared");
  a_flag_fall_cause: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(r.changed)
    |-> ($past(cfg.refresh_done) && $past(r.pending)))
    else $error("changed flag cleared without refresh");
  a_pending_on_apply: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    apply
    |=> r.pending)
    else $error("refresh request not remembered");
  a_pending_clears: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (cfg.refresh_done && !apply)
    |=> !r.pending)
    else $error("refresh request not retired");
  a_read_no_effect: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_rd && !i_table_write && !cfg.refresh_done)
    |=> r.changed == $past(r.changed))
    else $error("read disturbed flag");
  a_write_no_effect: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_wr && !i_table_write && !cfg.refresh_done)
    |=> r.changed == $past(r.changed))
    else $error("write disturbed flag");

  // refresh launch and working-table copy strobe
  a_apply_starts: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (apply && !cfg.refresh_busy)
    |=> cfg.refresh_busy)
    else $error("refresh not started");
  a_partial_write: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_cfg_wr && !(i_cfg_be[0] && i_cfg_wdata[APPLY_BIT]) && !cfg.refresh_busy)
    |=> !cfg.refresh_busy)
    else $error("refresh started without apply");
  a_copy_on_busy: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    cfg.refresh_busy
    |=> o_copy_en)
    else $error("copy strobe missing");
  a_copy_off_idle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !cfg.refresh_busy
    |=> !o_copy_en)
    else $error("copy strobe without refresh");

  c_table_write: cover property (@(posedge i_core_clk) i_table_write);
  c_refresh: cover property (@(posedge i_core_clk) r.changed ##1 apply ##[1:8] !r.changed);
  c_cap_read: cover property (@(posedge i_core_clk) i_cfg_rd && i_cfg_addr == CAP_OFFSET);
  c_set_wins: cover property (@(posedge i_core_clk)
    i_table_write && cfg.refresh_done && r.pending);
  c_partial_write: cover property (@(posedge i_core_clk)
    i_cfg_wr && !i_cfg_be[0] && i_cfg_wdata[APPLY_BIT]);
endmodule : vc_arbitration_status_capability_regs

// file: cfg_host_model.sv
// upstream host issuing config reads and writes to the vc register block
// assumes the bench calls its tasks; requests launch at the falling edge
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic i_core_clk, // core clock
  input wire logic [31:0] i_cfg_rdata, // read data
  input wire logic i_cfg_rvalid, // read data valid
  output logic o_cfg_rd = 1'b0, // read strobe
  output logic o_cfg_wr = 1'b0, // write strobe
  output logic [11:0] o_cfg_addr = 12'h000, // dword offset
  output logic [3:0] o_cfg_be = 4'h0, // byte enables
  output logic [31:0] o_cfg_wdata = 32'h0000_0000 // write data
);
  task automatic cfg_read(input logic [11:0] a, output logic [31:0] d, output logic v);
    @(negedge i_core_clk);
    o_cfg_rd = 1'b1;
    o_cfg_addr = a;
    @(negedge i_core_clk);
    o_cfg_rd = 1'b0;
    // released address inverted so a stale value never looks valid
    o_cfg_addr = ~a;
    d = i_cfg_rdata;
    v = i_cfg_rvalid;
  endtask : cfg_read
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] b, input logic [31:0] w);
    @(negedge i_core_clk);
    o_cfg_wr = 1'b1;
    o_cfg_addr = a;
    o_cfg_be = b;
    o_cfg_wdata = w;
    @(negedge i_core_clk);
    o_cfg_wr = 1'b0;
    o_cfg_addr = ~a;
    o_cfg_be = ~b;
    o_cfg_wdata = ~w;
  endtask : cfg_write
endmodule : cfg_host_model

// file: tb_vc_arbitration_status_capability_regs.sv
// self-checking bench for the vc status and capability registers
// assumes the host model drives config traffic at the falling edge
`timescale 1ns/1ps
module tb_vc_arbitration_status_capability_regs;
  import vc_arb_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic tw = 1'b0;
  logic rd, wr, rvalid, copy_en;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, d;
  logic [31:0] seed = 32'hB4AF;
  logic flag = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  int copy_cnt = 0;
  cfg_host_model host (.i_core_clk(clk), .i_cfg_rdata(rdata), .i_cfg_rvalid(rvalid),
    .o_cfg_rd(rd), .o_cfg_wr(wr), .o_cfg_addr(addr), .o_cfg_be(be), .o_cfg_wdata(wdata));
  vc_arbitration_status_capability_regs uut (.i_core_clk(clk), .i_arst_n(arst_n),
    .i_cfg_rd(rd), .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
    .i_table_write(tw), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_copy_en(copy_en));
  initial begin
    forever #5 clk = ~clk;
  end
  // cycles of working-table copying seen so far
  always @(posedge clk) begin
    if (copy_en === 1'b1) copy_cnt <= copy_cnt + 1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] exp_rd(input logic [11:0] a, input logic f);
    if (a == 12'h15C) return {15'h0000, f, 16'h0000};
    if (a == 12'h160) return 32'h0000_0001;
    return 32'h0000_0000;
  endfunction : exp_rd
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic rd_chk(input logic [11:0] a);
    logic v;
    host.cfg_read(a, d, v);
    check("rvalid", {31'h0000_0000, v}, 32'h0000_0001);
    check("rdata", d, exp_rd(a, flag));
  endtask : rd_chk
  task automatic pulse_table_write();
    @(negedge clk);
    tw = 1'b1;
    @(negedge clk);
    tw = 1'b0;
  endtask : pulse_table_write
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    rd_chk(12'h160);
    rd_chk(12'h160);
    rd_chk(12'h15C);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      // apply bit kept low so random writes never start a refresh
      if (seed[0]) host.cfg_write(seed[1] ? 12'h160 : 12'h15C, 4'hF, {seed[31:1], 1'b0});
      else rd_chk({seed[11:2], 2'b00});
      rd_chk(12'h15C);
    end
    host.cfg_write(12'h160, 4'hF, 32'hFFFF_FFFE);
    rd_chk(12'h160);
    pulse_table_write();
    flag = 1'b1;
    rd_chk(12'h15C);
    rd_chk(12'h15C);
    rd_chk(12'h160);
    // apply bit with its byte lane disabled: no refresh, flag stays
    host.cfg_write(12'h15C, 4'hE, 32'h0000_0001);
    repeat (8) @(negedge clk);
    check("copy_cnt", 32'(copy_cnt), 32'h0000_0000);
    rd_chk(12'h15C);
    host.cfg_write(12'h15C, 4'h1, 32'h0000_0001);
    rd_chk(12'h15C);
    repeat (8) @(negedge clk);
    check("copy_cnt", 32'(copy_cnt), 32'(REFRESH_CYCLES));
    flag = 1'b0;
    rd_chk(12'h15C);
    // table write lands in the completion cycle: set wins
    pulse_table_write();
    host.cfg_write(12'h15C, 4'h1, 32'h0000_0001);
    repeat (4) @(negedge clk);
    tw = 1'b1;
    @(negedge clk);
    tw = 1'b0;
    flag = 1'b1;
    repeat (4) @(negedge clk);
    check("copy_cnt", 32'(copy_cnt), 32'(2 * REFRESH_CYCLES));
    rd_chk(12'h15C);
    report_and_stop();
  end
  initial begin
    #50_000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_vc_arbitration_status_capability_regs
